// file: pkg/pmc_defines.svh
// Offsets, field positions, reset values and codes of the port 0 pin mode block.
// Assumes it is included by bare name from the package and design files.
`ifndef PMC_DEFINES_SVH
`define PMC_DEFINES_SVH

// Byte address of each pin mode register on the plain register port.
`define PMC_PORT0_PIN1_MODE_OFS 32'h5000_3020
`define PMC_PORT0_PIN2_MODE_OFS 32'h5000_3022
`define PMC_PORT0_PIN3_MODE_OFS 32'h5000_3024
`define PMC_PORT0_PIN4_MODE_OFS 32'h5000_3026
`define PMC_PORT0_PIN5_MODE_OFS 32'h5000_3028
`define PMC_PORT0_PIN6_MODE_OFS 32'h5000_302A

// Field positions inside a pin mode register.
`define PMC_DRV_POS  4'hA
`define PMC_DIR_POS  4'h8
`define PMC_FUNC_POS 4'h0

// Reset values of the fields.
`define PMC_DRV_RST      1'h0
`define PMC_DIR_RST      2'h2
`define PMC_DIR_RST_PIN5 2'h1
`define PMC_FUNC_RST     6'h00

// Function codes with special meaning to the pad logic.
`define PMC_FUNC_GPIO 6'h00
`define PMC_FUNC_ADC  6'h26

`endif

// file: pkg/pmc_pkg.sv
// Types shared by the port 0 pin mode block.
// Assumes the defines header sits on the include path.
`include "pmc_defines.svh"

package pmc_pkg;

  // Direction and pull selection of a pin.
  typedef enum logic [1:0] {
    PMC_IN_FLOAT  = 2'h0,
    PMC_IN_PULLUP = 2'h1,
    PMC_IN_PULLDN = 2'h2,
    PMC_OUT       = 2'h3
  } pmc_dir_type;

  // Function selector value of a pin.
  typedef logic [5:0] pmc_func_type;

endpackage : pmc_pkg

// file: rtl/pmc_pin_cell.sv
// Pad control of one pin: routes a function to the pad and sets drive and pulls.
// Assumes mode fields come from the register file of the top module.
`timescale 1ns/1ps
`include "pmc_defines.svh"

module pmc_pin_cell #(
  parameter int NFUNC = 64
) (
  input  wire logic                 drv_od,
  input  wire pmc_pkg::pmc_dir_type dir,
  input  wire pmc_pkg::pmc_func_type func,
  input  wire logic                 gpio_dout,
  input  wire logic [NFUNC-1:0]     periph_out,
  output logic                      pad_out,
  output logic                      pad_oe,
  output logic                      pull_up_en,
  output logic                      pull_dn_en,
  output logic                      ana_en,
  output logic                      dig_in
);

  // The analogue function overrides the direction field entirely.
  wire is_adc = (func == `PMC_FUNC_ADC);
  // Plain I/O takes its data from the port data register.
  wire is_gpio = (func == `PMC_FUNC_GPIO);
  // Direction field decode, masked in analogue mode.
  wire out_en = !is_adc && (dir == pmc_pkg::PMC_OUT);
  // Data that the pad would carry when driving.
  wire data = is_gpio ? gpio_dout : periph_out[func];

  // Open drain only pulls low; push-pull drives both levels.
  assign pad_out = drv_od ? 1'h0 : data;
  assign pad_oe = out_en && !(drv_od && data);
  // Pulls only in digital input modes.
  assign pull_up_en = !is_adc && (dir == pmc_pkg::PMC_IN_PULLUP);
  assign pull_dn_en = !is_adc && (dir == pmc_pkg::PMC_IN_PULLDN);
  assign ana_en = is_adc;
  // The pin offers its level to a peripheral input only for digital functions.
  assign dig_in = !is_adc && !is_gpio;

endmodule : pmc_pin_cell

// file: rtl/pmc_top.sv
// Port 0 pins 1 to 6 mode registers with pad routing and input priority.
// Assumes synchronous pad inputs and a master that keeps strobes one cycle long.
//
// The plain strobed port is this design's own decision.
`timescale 1ns/1ps
`include "pmc_defines.svh"

module pmc_top #(
  parameter int NFUNC = 64
) (
  input  wire logic              sys_clk,
  input  wire logic              nrst,
  input  wire logic [31:0]       addr,
  input  wire logic [15:0]       wdata,
  input  wire logic              wr,
  input  wire logic              rd,
  output logic      [15:0]       rdata,
  input  wire logic [5:0]        gpio_dout,
  output logic      [5:0]        gpio_din,
  input  wire logic [NFUNC-1:0]  periph_out,
  input  wire logic [5:0]        pad_in,
  output logic      [5:0]        pad_out,
  output logic      [5:0]        pad_oe,
  output logic      [5:0]        pull_up_en,
  output logic      [5:0]        pull_dn_en,
  output logic      [5:0]        ana_en,
  input  wire logic [NFUNC-1:0]  hi_prio_valid,
  input  wire logic [NFUNC-1:0]  hi_prio_in,
  input  wire logic [NFUNC-1:0]  lo_prio_valid,
  input  wire logic [NFUNC-1:0]  lo_prio_in,
  output logic      [NFUNC-1:0]  periph_in,
  output logic      [NFUNC-1:0]  periph_in_valid
);

  // Number of pins served; fixed by the register map.
  localparam int NPINS = 6;

  // Printed byte address of each pin register, index 0 is pin 1.
  localparam logic [31:0] OFS [NPINS] = '{
    `PMC_PORT0_PIN1_MODE_OFS, `PMC_PORT0_PIN2_MODE_OFS, `PMC_PORT0_PIN3_MODE_OFS,
    `PMC_PORT0_PIN4_MODE_OFS, `PMC_PORT0_PIN5_MODE_OFS, `PMC_PORT0_PIN6_MODE_OFS
  };

  // Index of pin 5 in the arrays.
  localparam int PIN5_IDX = 4;

  // Stored fields of each pin register.
  logic                  drv_r  [NPINS];
  pmc_pkg::pmc_dir_type  dir_r  [NPINS];
  pmc_pkg::pmc_func_type func_r [NPINS];
  // Registered read data.
  logic [15:0]           rdata_r;

  // Address match per register.
  logic [NPINS-1:0]      hit_w;
  // Register contents as read, reserved bits zero.
  logic [15:0]           view_w [NPINS];
  // Pins that offer their level to a peripheral input.
  logic [NPINS-1:0]      dig_in_w;
  // Read value selected by the address.
  logic [15:0]           rsel_w;

  // Per-pin decode, register storage and pad cell.
  genvar g;
  generate
    for (g = 0; g < NPINS; g++) begin : gen_pin
      // Address decode of this register.
      assign hit_w[g] = (addr == OFS[g]);
      // Read view: drive bit, direction, function, zeros elsewhere.
      assign view_w[g] = {5'h00, drv_r[g], dir_r[g], 2'h0, func_r[g]};

      // Storage; writes to reserved bits are dropped.
      always_ff @(posedge sys_clk) begin
        if (!nrst) begin
          drv_r[g]  <= `PMC_DRV_RST;
          dir_r[g]  <= pmc_pkg::pmc_dir_type'((g == PIN5_IDX) ?
                       `PMC_DIR_RST_PIN5 : `PMC_DIR_RST);
          func_r[g] <= `PMC_FUNC_RST;
        end else if (wr && hit_w[g]) begin
          drv_r[g]  <= wdata[`PMC_DRV_POS];
          dir_r[g]  <= pmc_pkg::pmc_dir_type'(wdata[`PMC_DIR_POS +: 2]);
          func_r[g] <= wdata[`PMC_FUNC_POS +: 6];
        end
      end

      // Pad control of this pin.
      pmc_pin_cell #(
        .NFUNC (NFUNC)
      ) u_cell (
        .drv_od     (drv_r[g]),
        .dir        (dir_r[g]),
        .func       (func_r[g]),
        .gpio_dout  (gpio_dout[g]),
        .periph_out (periph_out),
        .pad_out    (pad_out[g]),
        .pad_oe     (pad_oe[g]),
        .pull_up_en (pull_up_en[g]),
        .pull_dn_en (pull_dn_en[g]),
        .ana_en     (ana_en[g]),
        .dig_in     (dig_in_w[g])
      );

      // The port data register sees the pad except in analogue mode.
      assign gpio_din[g] = pad_in[g] && !ana_en[g];
    end
  endgenerate

  // Read select; an unmapped address reads zero.
  always_comb begin
    rsel_w = 16'h0000;
    for (int i = 0; i < NPINS; i++) begin
      if (hit_w[i]) begin
        rsel_w = view_w[i];
      end
    end
  end

  // Read data is captured on the read strobe and stands for one cycle.
  always_ff @(posedge sys_clk) begin
    if (!nrst) begin
      rdata_r <= 16'h0000;
    end else begin
      rdata_r <= rd ? rsel_w : 16'h0000;
    end
  end

  assign rdata = rdata_r;

  // Input routing: pin 0 outside wins, then the lowest pin here, then later ports.
  always_comb begin
    periph_in       = lo_prio_in;
    periph_in_valid = lo_prio_valid;
    // Walk from the highest pin down so that the lowest match is left standing.
    for (int i = NPINS - 1; i >= 0; i--) begin
      if (dig_in_w[i]) begin
        periph_in[func_r[i]]       = pad_in[i];
        periph_in_valid[func_r[i]] = 1'h1;
      end
    end
    // The lower-indexed pin of this port beats every pin here.
    for (int f = 0; f < NFUNC; f++) begin
      if (hi_prio_valid[f]) begin
        periph_in[f]       = hi_prio_in[f];
        periph_in_valid[f] = 1'h1;
      end
    end
  end

  // Checks run on the system clock and rest during reset.
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!nrst);

  // Helper: pins 1 and 2 share one digital input function.
  wire clash_w = dig_in_w[0] && dig_in_w[1] && (func_r[0] == func_r[1]);

  generate
    for (g = 0; g < NPINS; g++) begin : gen_chk
      AST_OPEN_DRAIN_LOW: assert property (
        drv_r[g] |-> (pad_out[g] == 1'h0))
        else $error("Open-drain pin drives a high level.");
      AST_PUSH_PULL_DRIVES: assert property (
        (!drv_r[g] && !ana_en[g] && dir_r[g] == pmc_pkg::PMC_OUT) |-> pad_oe[g])
        else $error("Push-pull output pin is not driven.");
      AST_INPUT_PULLS: assert property (
        (!ana_en[g] && dir_r[g] != pmc_pkg::PMC_OUT) |->
        (!pad_oe[g] && pull_up_en[g] == (dir_r[g] == pmc_pkg::PMC_IN_PULLUP)
         && pull_dn_en[g] == (dir_r[g] == pmc_pkg::PMC_IN_PULLDN)))
        else $error("Input pin has wrong pulls or drives.");
      AST_OUTPUT_NO_PULL: assert property (
        (dir_r[g] == pmc_pkg::PMC_OUT) |-> (!pull_up_en[g] && !pull_dn_en[g]))
        else $error("Output pin has a pull resistor on.");
      AST_ADC_OVERRIDE: assert property (
        (func_r[g] == `PMC_FUNC_ADC) |->
        (ana_en[g] && !pad_oe[g] && !pull_up_en[g] && !pull_dn_en[g]))
        else $error("Analogue pin obeys the direction field.");
      AST_FUNC_WRITE: assert property (
        (wr && hit_w[g]) |=> (func_r[g] == $past(wdata[5:0])) ##1
        (!$past(wr) || !$past(hit_w[g]) || func_r[g] == $past(func_r[g])))
        else $error("Function selector did not take or hold the write.");
      AST_GPIO_DATA: assert property (
        (func_r[g] == `PMC_FUNC_GPIO && !drv_r[g] && dir_r[g] == pmc_pkg::PMC_OUT)
        |-> (pad_oe[g] && pad_out[g] == gpio_dout[g]))
        else $error("Plain I/O pin does not drive the port data.");
      AST_INPUT_PRIORITY: assert property (
        (dig_in_w[g] && !hi_prio_valid[func_r[g]] &&
         (g == 0 || !dig_in_w[0] || func_r[0] != func_r[g])) |->
        (g != 1 || periph_in[func_r[g]] == pad_in[g]))
        else $error("Second pin beat no lower pin yet lost the input.");
    end
  endgenerate

  AST_CLASH_LOWEST: assert property (
    (clash_w && !hi_prio_valid[func_r[0]]) |-> (periph_in[func_r[0]] == pad_in[0]))
    else $error("Shared input is not fed by the lowest pin.");

  AST_READ_RESERVED: assert property (
    rd |=> (rdata[15:11] == 5'h00 && rdata[7:6] == 2'h0) ##1 (rdata == 16'h0000 || $past(rd)))
    else $error("Reserved bits or stale read data seen.");

  AST_READ_VALUE: assert property (
    (rd && hit_w[0]) |=> (rdata[5:0] == $past(func_r[0])))
    else $error("Read of pin 1 returns the wrong function.");

  // Main scenarios worth seeing.
  COV_OPEN_DRAIN: cover property (drv_r[1] && dir_r[1] == pmc_pkg::PMC_OUT ##1 !pad_oe[1]);
  COV_ADC_MODE: cover property (ana_en[2] && dir_r[2] == pmc_pkg::PMC_OUT);
  COV_CLASH: cover property (clash_w);
  COV_PULLUP: cover property (pull_up_en[PIN5_IDX] ##1 wr && hit_w[PIN5_IDX]);

endmodule : pmc_top

// file: verification/pmc_pad_model.sv
// Behavioural pads of port 0 pins 1 to 6 as seen from outside the package.
// Assumes the bench acts as an outside source through ext_en and ext_drv.
`timescale 1ns/1ps

module pmc_pad_model (
  input  wire logic       sys_clk,
  input  wire logic [5:0] pad_out,
  input  wire logic [5:0] pad_oe,
  input  wire logic [5:0] pull_up_en,
  input  wire logic [5:0] pull_dn_en,
  input  wire logic [5:0] ext_en,
  input  wire logic [5:0] ext_drv,
  output logic      [5:0] pad_in
);
  // Level of a pad that nobody drives or pulls; it changes every cycle on purpose.
  logic [5:0] float_r = 6'h15;

  // The floating level toggles so a stale value can never pass as a real one.
  always_ff @(posedge sys_clk) begin
    float_r <= ~float_r;
  end

  // Pad driver first, then an outside source, then the pulls, else the floating level.
  always_comb begin
    for (int i = 0; i < 6; i++) begin
      if (pad_oe[i]) begin
        pad_in[i] = pad_out[i];
      end else if (ext_en[i]) begin
        pad_in[i] = ext_drv[i];
      end else if (pull_up_en[i]) begin
        pad_in[i] = 1'h1;
      end else if (pull_dn_en[i]) begin
        pad_in[i] = 1'h0;
      end else begin
        pad_in[i] = float_r[i];
      end
    end
  end
endmodule : pmc_pad_model

// file: verification/port0_pin_mode_config_tb.sv
// Self-checking bench of the port 0 pin mode block with a pad model.
// Assumes the defines header is on the include path.
`timescale 1ns/1ps
`include "pmc_defines.svh"

module port0_pin_mode_config_tb;
  logic        sys_clk, nrst, wr, rd;
  logic [31:0] addr;
  logic [15:0] wdata, rdata;
  logic [5:0]  gpio_dout, gpio_din, pad_in, pad_out, pad_oe;
  logic [5:0]  pull_up_en, pull_dn_en, ana_en, ext_en, ext_drv;
  logic [63:0] periph_out, hi_v, hi_in, lo_v, lo_in, periph_in, periph_in_valid;
  int          failures, total_checks, cycles;

  pmc_top u_dut (.sys_clk(sys_clk), .nrst(nrst), .addr(addr), .wdata(wdata), .wr(wr),
    .rd(rd), .rdata(rdata), .gpio_dout(gpio_dout), .gpio_din(gpio_din),
    .periph_out(periph_out), .pad_in(pad_in), .pad_out(pad_out), .pad_oe(pad_oe),
    .pull_up_en(pull_up_en), .pull_dn_en(pull_dn_en), .ana_en(ana_en),
    .hi_prio_valid(hi_v), .hi_prio_in(hi_in), .lo_prio_valid(lo_v), .lo_prio_in(lo_in),
    .periph_in(periph_in), .periph_in_valid(periph_in_valid));

  pmc_pad_model u_pad (.sys_clk(sys_clk), .pad_out(pad_out), .pad_oe(pad_oe),
    .pull_up_en(pull_up_en), .pull_dn_en(pull_dn_en), .ext_en(ext_en), .ext_drv(ext_drv),
    .pad_in(pad_in));

  // Byte address of the mode register of pin p.
  function automatic logic [31:0] ofs(input int p);
    return `PMC_PORT0_PIN1_MODE_OFS + 32'(2 * (p - 1));
  endfunction : ofs

  // Compares one value and counts the outcome.
  task automatic chk(input string nm, input logic [15:0] seen, input logic [15:0] exp);
    total_checks++;
    if (seen !== exp) begin
      failures++;
      $display("[ERR] %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk

  // One-cycle write; returns just after the edge that takes it.
  task automatic wr_reg(input logic [31:0] a, input logic [15:0] d);
    @(posedge sys_clk);
    wr <= 1'h1;
    addr <= a;
    wdata <= d;
    @(posedge sys_clk);
    wr <= 1'h0;
    #1;
  endtask : wr_reg

  // One-cycle read; the data stand only in the cycle after the strobe.
  task automatic rd_chk(input logic [31:0] a, input logic [15:0] exp);
    @(posedge sys_clk);
    rd <= 1'h1;
    addr <= a;
    @(posedge sys_clk);
    rd <= 1'h0;
    #1;
    chk("rdata", rdata, exp);
  endtask : rd_chk

  // Prints the counts and the verdict, then ends the run.
  task automatic finish_test();
    $display("checks %0d failures %0d", total_checks, failures);
    if (failures == 0 && total_checks > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask : finish_test

  // Free-running 125 MHz clock.
  initial begin
    sys_clk = 1'h0;
    forever #4 sys_clk = ~sys_clk;
  end

  // Cuts a hang short well after the sequence should be over.
  always @(posedge sys_clk) begin
    cycles++;
    if (cycles == 2000) begin
      failures++;
      finish_test();
    end
  end

  // Main sequence.
  initial begin
    {nrst, wr, rd, addr, wdata, gpio_dout, ext_en, ext_drv} = '0;
    {periph_out, hi_v, hi_in, lo_v, lo_in} = '0;
    repeat (3) @(posedge sys_clk);
    nrst <= 1'h1;
    for (int p = 1; p < 7; p++) begin
      rd_chk(ofs(p), (p == 5) ? 16'h0100 : 16'h0200);
    end
    chk("pulls", {4'h0, pull_up_en, pull_dn_en}, 16'h042F);
    chk("oe_ana", {4'h0, pad_oe, ana_en}, 16'h0000);
    chk("claims", periph_in_valid[15:0], 16'h0000);
    // Pin 5 leaves its pull-up for open drain with pull-down and reads back.
    wr_reg(ofs(5), 16'h0600);
    rd_chk(ofs(5), 16'h0600);
    wr_reg(ofs(1), 16'hFFFF);
    rd_chk(ofs(1), 16'h073F);
    wr_reg(32'h5000_302C, 16'h0300);
    wr_reg(ofs(2) + 32'h1, 16'h0300);
    rd_chk(32'h5000_302C, 16'h0000);
    rd_chk(ofs(2), 16'h0200);
    @(posedge sys_clk);
    gpio_dout <= 6'h02;
    for (int d = 0; d < 4; d++) begin
      wr_reg(ofs(2), {6'h00, 2'(d), 8'h00});
      chk("dir", {13'h0, pad_oe[1], pull_dn_en[1], pull_up_en[1]},
          {13'h0, d == 3, d == 2, d == 1});
    end
    chk("pushpull", {14'h0, pad_out[1], gpio_din[1]}, 16'h0003);
    wr_reg(ofs(2), 16'h0700);
    chk("od_high", {15'h0, pad_oe[1]}, 16'h0000);
    @(posedge sys_clk);
    gpio_dout <= 6'h00;
    #1;
    chk("od_low", {14'h0, pad_oe[1], pad_out[1]}, 16'h0002);
    wr_reg(ofs(2), 16'h030C);
    @(posedge sys_clk);
    periph_out[12] <= 1'h1;
    #1;
    chk("periph", {14'h0, pad_oe[1], pad_out[1]}, 16'h0003);
    for (int d = 0; d < 4; d++) begin
      wr_reg(ofs(3), {6'h00, 2'(d), 2'h0, `PMC_FUNC_ADC});
      chk("adc", {13'h0, ana_en[2], pad_oe[2], gpio_din[2]}, 16'h0004);
    end
    wr_reg(ofs(4), 16'h000B);
    wr_reg(ofs(6), 16'h000B);
    @(posedge sys_clk);
    ext_en <= 6'h28;
    ext_drv <= 6'h08;
    #1;
    chk("prio_lo_pin", {14'h0, periph_in[11], periph_in_valid[11]}, 16'h0003);
    @(posedge sys_clk);
    ext_drv <= 6'h20;
    #1;
    chk("prio_lo_pin", {14'h0, periph_in[11], periph_in_valid[11]}, 16'h0001);
    @(posedge sys_clk);
    hi_v[11] <= 1'h1;
    hi_in[11] <= 1'h1;
    #1;
    chk("prio_pin0", {14'h0, periph_in[11], periph_in_valid[11]}, 16'h0003);
    // Port 1 offers a high level, so a wrong winner shows as a high input.
    @(posedge sys_clk);
    hi_v[11] <= 1'h0;
    lo_v[11] <= 1'h1;
    lo_in[11] <= 1'h1;
    #1;
    chk("prio_port1", {14'h0, periph_in[11], periph_in_valid[11]}, 16'h0001);
    wr_reg(ofs(4), 16'h0000);
    wr_reg(ofs(6), 16'h0000);
    chk("port1_only", {14'h0, periph_in[11], periph_in_valid[11]}, 16'h0003);
    // Pins 1 and 2 claim one input; pin 1 is held low, pin 2 is pulled high.
    @(posedge sys_clk);
    ext_en <= 6'h01;
    ext_drv <= 6'h00;
    wr_reg(ofs(1), 16'h000B);
    wr_reg(ofs(2), 16'h010B);
    chk("prio_pin1", {14'h0, periph_in[11], periph_in_valid[11]}, 16'h0001);
    finish_test();
  end
endmodule : port0_pin_mode_config_tb
